// [fpxfr_pkg.sv]
package fpxfr_pkg;

   // ==========================================================
   // instruction field layout
   localparam int OFF_LSB = 0;
   localparam int OFF_W = 8;
   localparam int CP_LSB = 8;
   localparam int CP_W = 4;
   localparam int FD_LSB = 12;
   localparam int LEN_LO_BIT = 15;
   localparam int RN_LSB = 16;
   localparam int LS_BIT = 20;
   localparam int WB_BIT = 21;
   localparam int LEN_HI_BIT = 22;
   localparam int UD_BIT = 23;
   localparam int P_BIT = 24;
   localparam int CLS_LSB = 25;
   localparam logic [2:0] CLS_CPDT = 3'h6;
   localparam logic [3:0] CP_SINGLE = 4'h1;
   localparam logic [3:0] CP_GROUP = 4'h2;

   // ==========================================================
   // sizes and reset values
   localparam int NUM_FREGS = 8;
   localparam int WORDS_PER_REG = 3;
   localparam int FIFO_DEPTH = 4;
   localparam logic [1:0] WORD_SHIFT = 2'h2;
   localparam logic [31:0] WORD_BYTES = 32'h4;
   localparam logic [31:0] WORD_RST = 32'h0;
   localparam logic [4:0] SW_STATUS_IDX = 5'h18;

   // ==========================================================
   // exponent rebias between internal extended and memory formats
   localparam logic [14:0] SGL_REBIAS = 15'h3F80;
   localparam logic [14:0] DBL_REBIAS = 15'h3C00;

   typedef enum logic [2:0] {
      FMT_SINGLE, FMT_DOUBLE, FMT_EXTENDED, FMT_PACKED, FMT_EXP_PACKED
   } fpxfr_fmt_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic write;
   } fpxfr_memreq_t;

endpackage : fpxfr_pkg

// [fpxfr_core.sv]
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// shift fifo: head entry is always a flop
module fpxfr_fifo #(
   parameter int WIDTH = 65,
   parameter int DEPTH = 4
) (
   input wire logic clk, // core clock
   input wire logic rst_n, // sync reset, active low
   input wire logic inValid, // push request
   output logic inReady, // room for a push
   input wire logic [WIDTH-1:0] inData, // pushed word
   output logic outValid, // head holds data
   input wire logic outReady, // drain side takes head
   output logic [WIDTH-1:0] outData // head word
);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [DEPTH-1:0] vld_ff;
   logic [DEPTH:0] vExt;
   logic [DEPTH-1:0] sv;
   logic [DEPTH-1:0] slot;
   logic push;
   logic pop;

   assign inReady = ~vld_ff[DEPTH-1];
   assign outValid = vld_ff[0];
   assign outData = mem_ff[0];
   assign push = inValid & inReady;
   assign pop = vld_ff[0] & outReady;
   assign vExt = {1'b0, vld_ff};

   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      logic [WIDTH-1:0] nxt_mem;
      assign sv[i] = pop ? vExt[i+1] : vExt[i];
      if (i == 0) begin : g_first
         assign slot[i] = push & ~sv[i];
      end else begin : g_rest
         assign slot[i] = push & ~sv[i] & sv[i-1];
      end
      if (i == DEPTH - 1) begin : g_top
         assign nxt_mem = slot[i] ? inData : mem_ff[i];
      end else begin : g_mid
         assign nxt_mem = slot[i] ? inData : (pop ? mem_ff[i+1] : mem_ff[i]);
      end
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            mem_ff[i] <= '0;
            vld_ff[i] <= 1'b0;
         end else begin
            mem_ff[i] <= nxt_mem;
            vld_ff[i] <= sv[i] | slot[i];
         end
      end
   end
endmodule : fpxfr_fifo

// Behaviour
// RULE_01 - index bit 1 uses modified base as address, 0 uses original base
// RULE_02 - 8-bit offset counts words; added when up bit 1, subtracted when 0
// RULE_03 - base update bit 1 writes modified base back, 0 keeps original
// RULE_04 - post-indexing never writes back unless base update bit is set
// RULE_05 - first word at computed address, each next word four bytes higher
// RULE_06 - single transfer: direction bit 0 stores, 1 loads, one of five formats
// RULE_07 - length bits 22,15 pick single, double, extended, packed or expanded packed
// RULE_08 - stores round to nearest into destination precision, exact when it fits
// RULE_09 - single transfers use coprocessor number 1, group transfers number 2
// RULE_10 - group transfers move one to four float registers in one operation
// RULE_11 - group count bits 22,15: 01 one, 10 two, 11 three, 00 four
// RULE_12 - group transfer starts with the named first float register
// RULE_13 - group registers ascend and wrap from seven back to zero
// RULE_14 - each group register takes three memory words in internal format
// RULE_15 - software only reloads group store data with a group load
// RULE_16 - issuer avoids program counter as post-indexed or written-back base
// RULE_17 - issuer keeps byte offset a multiple of four within plus minus 1020
// RULE_18 - only instructions with our two coprocessor numbers are claimed
// RULE_19 - packed decimal lengths are refused and left to software emulation
module fpxfr_core (
   input wire logic ref_clk, // core clock, 10 MHz
   input wire logic rst_n, // sync reset, active low
   input wire logic insValid, // instruction offered
   input wire logic [31:0] insWord, // instruction word
   input wire logic [31:0] insBase, // value of the named base register
   input wire logic expandedPackedSelect, // chooses expanded packed length
   output logic insReady, // block idle, takes an instruction
   output logic insClaim, // pulse: instruction claimed
   output logic insRefuse, // pulse: instruction left to host
   output logic memValid, // memory word request valid
   output fpxfr_pkg::fpxfr_memreq_t memReq, // address, store data, write flag
   input wire logic memReady, // host takes the request
   input wire logic rdValid, // load data word from host
   input wire logic [31:0] rdData, // load data, in request order
   output logic baseWbValid, // pulse: write base register back
   output logic [3:0] baseWbIndex, // base register to write
   output logic [31:0] baseWbValue, // new base value
   output logic xferDone, // pulse: transfer finished
   input wire logic [4:0] swAddr, // float register word index
   input wire logic [31:0] swWdata, // software write data
   input wire logic swWr, // software write strobe
   input wire logic swRd, // software read strobe
   output logic [31:0] swRdata // read data, cycle after the strobe
);
   import fpxfr_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_FINISH} fpxfr_state_t;

   // ==========================================================
   // functions
   function automatic fpxfr_fmt_t decodeFmt(input logic [1:0] len, input logic eps);
      unique case (len)
         2'h0: decodeFmt = FMT_SINGLE;
         2'h1: decodeFmt = FMT_DOUBLE;
         2'h2: decodeFmt = FMT_EXTENDED;
         2'h3: decodeFmt = eps ? FMT_EXP_PACKED : FMT_PACKED; // [RULE_07]
      endcase
   endfunction : decodeFmt

   function automatic logic [3:0] fmtWords(input fpxfr_fmt_t f);
      unique case (f)
         FMT_SINGLE: fmtWords = 4'h1;
         FMT_DOUBLE: fmtWords = 4'h2;
         FMT_EXP_PACKED: fmtWords = 4'h4;
         default: fmtWords = 4'h3;
      endcase
   endfunction : fmtWords

   function automatic logic [4:0] wordIdx(input logic [2:0] r, input logic [1:0] w);
      wordIdx = 5'({r, 1'b0}) + 5'(r) + 5'(w);
   endfunction : wordIdx

   // internal form: w0 sign and 15-bit exponent, w1:w2 mantissa with explicit one
   function automatic logic [95:0] toMem(input fpxfr_fmt_t f, input logic [31:0] w0,
                                         input logic [31:0] w1, input logic [31:0] w2);
      logic [63:0] m;
      logic zero;
      logic inc;
      logic [23:0] rs;
      logic [52:0] rd;
      logic [14:0] e;
      m = {w1, w2};
      zero = (w0[14:0] == 15'h0) && (m == 64'h0);
      inc = 1'b0;
      rs = '0;
      rd = '0;
      e = '0;
      toMem = {w0, w1, w2};
      if (f == FMT_SINGLE) begin
         // guard bit set and (sticky or odd lsb): nearest, ties to even
         inc = m[39] & ((|m[38:0]) | m[40]); // [RULE_08]
         rs = {1'b0, m[62:40]} + 24'(inc);
         e = w0[14:0] - SGL_REBIAS + 15'(rs[23]);
         toMem = zero ? {w0[31], 95'h0} : {w0[31], e[7:0], rs[22:0], 64'h0};
      end else if (f == FMT_DOUBLE) begin
         inc = m[10] & ((|m[9:0]) | m[11]); // [RULE_08]
         rd = {1'b0, m[62:11]} + 53'(inc);
         e = w0[14:0] - DBL_REBIAS + 15'(rd[52]);
         toMem = zero ? {w0[31], 95'h0} : {w0[31], e[10:0], rd[51:0], 32'h0};
      end
   endfunction : toMem

   function automatic logic [95:0] fromMem(input fpxfr_fmt_t f, input logic [31:0] d0,
                                           input logic [31:0] d1, input logic [31:0] d2);
      logic zero;
      fromMem = {d0, d1, d2};
      zero = (d0[30:0] == 31'h0);
      if (f == FMT_SINGLE) begin
         zero = (d0[30:0] == 31'h0);
         fromMem = zero ? {d0[31], 95'h0} :
            {d0[31], 16'h0, 15'(d0[30:23]) + SGL_REBIAS, 1'b1, d0[22:0], 8'h0, 32'h0};
      end else if (f == FMT_DOUBLE) begin
         zero = (d0[30:0] == 31'h0) && (d1 == 32'h0);
         fromMem = zero ? {d0[31], 95'h0} :
            {d0[31], 16'h0, 15'(d0[30:20]) + DBL_REBIAS, 1'b1, d0[19:0], d1, 11'h0};
      end
   endfunction : fromMem

   // ==========================================================
   // state
   logic [31:0] fregs_ff [NUM_FREGS * WORDS_PER_REG];
   logic [31:0] stBuf_ff [WORDS_PER_REG];
   logic [31:0] ldBuf_ff [WORDS_PER_REG];
   fpxfr_state_t state_ff, nxt_state;
   fpxfr_fmt_t fmt_ff;
   logic isLoad_ff;
   logic isGroup_ff;
   logic [2:0] fd_ff;
   logic [3:0] nWords_ff;
   logic [3:0] issued_ff;
   logic [3:0] recvd_ff;
   logic [2:0] issReg_ff;
   logic [1:0] issWrd_ff;
   logic [2:0] rcvReg_ff;
   logic [1:0] rcvWrd_ff;
   logic [31:0] addr_ff;
   logic wbPend_ff;
   logic [3:0] wbIdx_ff;
   logic [31:0] wbVal_ff;
   logic insReady_ff, insClaim_ff, insRefuse_ff;
   logic baseWbValid_ff, xferDone_ff;
   logic [3:0] baseWbIndex_ff;
   logic [31:0] baseWbValue_ff;
   logic [31:0] swRdata_ff;

   // ==========================================================
   // decode of the offered instruction
   logic [1:0] lenCode;
   logic [3:0] cpNum;
   logic isOurs;
   logic isGrp;
   logic isPacked;
   logic take;
   logic claim;
   fpxfr_fmt_t fmt;
   logic [2:0] fd;
   logic [2:0] grpCount;
   logic [3:0] nWords;
   logic [31:0] offBytes;
   logic [31:0] modBase;
   logic [31:0] xferAddr;
   logic [95:0] stConv;
   logic [4:0] fdBase;

   assign lenCode = {insWord[LEN_HI_BIT], insWord[LEN_LO_BIT]};
   assign cpNum = insWord[CP_LSB +: CP_W];
   assign isGrp = (cpNum == CP_GROUP); // [RULE_09]
   assign isOurs = (insWord[CLS_LSB +: 3] == CLS_CPDT) &&
                   ((cpNum == CP_SINGLE) || isGrp); // [RULE_18]
   assign fmt = decodeFmt(lenCode, expandedPackedSelect);
   // packed decimal has no hardware here; the host traps to its emulation
   assign isPacked = !isGrp && ((fmt == FMT_PACKED) || (fmt == FMT_EXP_PACKED)); // [RULE_19]
   assign take = insValid && insReady_ff;
   assign claim = isOurs && !isPacked;
   assign fd = insWord[FD_LSB +: 3];
   assign grpCount = (lenCode == 2'h0) ? 3'h4 : {1'b0, lenCode}; // [RULE_11]
   assign nWords = isGrp ? 4'({grpCount, 1'b0}) + 4'(grpCount) : fmtWords(fmt); // [RULE_14]
   assign offBytes = {22'h0, insWord[OFF_LSB +: OFF_W], WORD_SHIFT'(0)};
   assign modBase = insWord[UD_BIT] ? insBase + offBytes : insBase - offBytes; // [RULE_02]
   assign xferAddr = insWord[P_BIT] ? modBase : insBase; // [RULE_01]
   assign fdBase = wordIdx(fd, 2'h0);
   assign stConv = toMem(fmt, fregs_ff[fdBase], fregs_ff[fdBase + 5'h1],
                         fregs_ff[fdBase + 5'h2]);

   // ==========================================================
   // word issue and load receive
   logic fifoReady;
   logic push;
   logic rcv;
   logic issueDone;
   logic recvDone;
   logic [31:0] pushData;
   fpxfr_memreq_t pushReq;
   logic [95:0] ldConv;
   logic swWrEn;

   assign issueDone = (issued_ff == nWords_ff);
   assign recvDone = !isLoad_ff || (recvd_ff == nWords_ff);
   assign push = (state_ff == ST_ISSUE) && !issueDone && fifoReady;
   assign rcv = rdValid && isLoad_ff && (state_ff == ST_ISSUE) && !recvDone;
   assign pushData = isLoad_ff ? WORD_RST :
                     isGroup_ff ? fregs_ff[wordIdx(issReg_ff, issWrd_ff)] :
                     stBuf_ff[issued_ff[1:0]];
   assign pushReq = '{addr: addr_ff, data: pushData, write: !isLoad_ff}; // [RULE_06]
   assign ldConv = fromMem(fmt_ff, ldBuf_ff[0], ldBuf_ff[1], ldBuf_ff[2]);
   assign swWrEn = swWr && (swAddr < SW_STATUS_IDX);

   fpxfr_fifo #(
      .WIDTH($bits(fpxfr_memreq_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .rst_n(rst_n),
      .inValid(push),
      .inReady(fifoReady),
      .inData(pushReq),
      .outValid(memValid),
      .outReady(memReady),
      .outData(memReq)
   );

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: if (take && claim) nxt_state = ST_ISSUE;
         ST_ISSUE: if (issueDone && recvDone && !memValid) nxt_state = ST_FINISH;
         ST_FINISH: nxt_state = ST_IDLE;
      endcase
   end

   // ==========================================================
   // control registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         fmt_ff <= FMT_SINGLE;
         isLoad_ff <= 1'b0;
         isGroup_ff <= 1'b0;
         fd_ff <= '0;
         nWords_ff <= '0;
         addr_ff <= WORD_RST;
         wbPend_ff <= 1'b0;
         wbIdx_ff <= '0;
         wbVal_ff <= WORD_RST;
      end else begin
         state_ff <= nxt_state;
         if (take && claim) begin
            fmt_ff <= fmt;
            isLoad_ff <= insWord[LS_BIT]; // [RULE_06]
            isGroup_ff <= isGrp; // [RULE_10]
            fd_ff <= fd;
            nWords_ff <= nWords;
            addr_ff <= xferAddr;
            // post-indexing alone never writes back
            wbPend_ff <= insWord[WB_BIT]; // [RULE_03] [RULE_04]
            wbIdx_ff <= insWord[RN_LSB +: 4];
            wbVal_ff <= modBase; // [RULE_03]
         end else if (push) begin
            addr_ff <= addr_ff + WORD_BYTES; // [RULE_05]
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         issued_ff <= '0;
         recvd_ff <= '0;
         issReg_ff <= '0;
         issWrd_ff <= '0;
         rcvReg_ff <= '0;
         rcvWrd_ff <= '0;
      end else if (take && claim) begin
         issued_ff <= '0;
         recvd_ff <= '0;
         issReg_ff <= fd; // [RULE_12]
         issWrd_ff <= '0;
         rcvReg_ff <= fd; // [RULE_12]
         rcvWrd_ff <= '0;
      end else begin
         if (push) begin
            issued_ff <= issued_ff + 4'h1;
            issWrd_ff <= (issWrd_ff == 2'h2) ? 2'h0 : issWrd_ff + 2'h1;
            // three-bit index wraps from seven to zero by itself
            if (issWrd_ff == 2'h2) issReg_ff <= issReg_ff + 3'h1; // [RULE_13]
         end
         if (rcv) begin
            recvd_ff <= recvd_ff + 4'h1;
            rcvWrd_ff <= (rcvWrd_ff == 2'h2) ? 2'h0 : rcvWrd_ff + 2'h1;
            if (rcvWrd_ff == 2'h2) rcvReg_ff <= rcvReg_ff + 3'h1; // [RULE_13]
         end
      end
   end

   // ==========================================================
   // staging buffers and float register file
   for (genvar k = 0; k < WORDS_PER_REG; k++) begin : g_buf
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            stBuf_ff[k] <= WORD_RST;
            ldBuf_ff[k] <= WORD_RST;
         end else begin
            // rounding is done once, at acceptance, from the source register
            if (take && claim) stBuf_ff[k] <= stConv[95 - 32 * k -: 32]; // [RULE_08]
            if (rcv && !isGroup_ff && (recvd_ff[1:0] == 2'(k))) ldBuf_ff[k] <= rdData;
         end
      end
   end

   // loads win over a software write to the same word
   for (genvar j = 0; j < NUM_FREGS * WORDS_PER_REG; j++) begin : g_freg
      logic grpHit;
      logic sglHit;
      assign grpHit = rcv && isGroup_ff && (wordIdx(rcvReg_ff, rcvWrd_ff) == 5'(j));
      assign sglHit = (state_ff == ST_FINISH) && isLoad_ff && !isGroup_ff &&
                      (wordIdx(fd_ff, 2'h0) == 5'(j - j % WORDS_PER_REG));
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            fregs_ff[j] <= WORD_RST;
         end else if (grpHit) begin
            fregs_ff[j] <= rdData; // [RULE_14]
         end else if (sglHit) begin
            fregs_ff[j] <= ldConv[95 - 32 * (j % WORDS_PER_REG) -: 32]; // [RULE_06]
         end else if (swWrEn && (swAddr == 5'(j))) begin
            fregs_ff[j] <= swWdata;
         end
      end
   end

   // ==========================================================
   // outputs
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         insReady_ff <= 1'b0;
         insClaim_ff <= 1'b0;
         insRefuse_ff <= 1'b0;
         baseWbValid_ff <= 1'b0;
         baseWbIndex_ff <= '0;
         baseWbValue_ff <= WORD_RST;
         xferDone_ff <= 1'b0;
         swRdata_ff <= WORD_RST;
      end else begin
         insReady_ff <= (nxt_state == ST_IDLE);
         insClaim_ff <= take && claim;
         insRefuse_ff <= take && !claim; // [RULE_18] [RULE_19]
         baseWbValid_ff <= (state_ff == ST_FINISH) && wbPend_ff; // [RULE_03]
         if ((state_ff == ST_FINISH) && wbPend_ff) begin
            baseWbIndex_ff <= wbIdx_ff;
            baseWbValue_ff <= wbVal_ff;
         end
         xferDone_ff <= (state_ff == ST_FINISH);
         if (swRd) begin
            swRdata_ff <= (swAddr < SW_STATUS_IDX) ? fregs_ff[swAddr] :
                          (swAddr == SW_STATUS_IDX) ? {31'h0, state_ff != ST_IDLE} :
                          WORD_RST;
         end else begin
            swRdata_ff <= WORD_RST;
         end
      end
   end

   assign insReady = insReady_ff;
   assign insClaim = insClaim_ff;
   assign insRefuse = insRefuse_ff;
   assign baseWbValid = baseWbValid_ff;
   assign baseWbIndex = baseWbIndex_ff;
   assign baseWbValue = baseWbValue_ff;
   assign xferDone = xferDone_ff;
   assign swRdata = swRdata_ff;
endmodule : fpxfr_core

`default_nettype wire

// [fpxfr_host_mem.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// host side: takes word requests, returns load data
module fpxfr_host_mem
   import fpxfr_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rst_n, // sync reset
   input wire logic memValid, // request valid
   input wire fpxfr_pkg::fpxfr_memreq_t memReq, // request
   output logic memReady, // take request
   output logic rdValid, // load word valid
   output logic [31:0] rdData, // load word
   input wire logic slow // stall three of four cycles
);
   logic [31:0] mem [0:127];
   logic [1:0] stall_ff;
   wire take = memValid && memReady;
   assign memReady = !slow || stall_ff == 2'h3;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         stall_ff <= 2'h0;
         rdValid <= 1'b0;
         rdData <= 32'h0;
      end else begin
         stall_ff <= stall_ff + 2'h1;
         rdValid <= take && !memReq.write;
         // idle data keeps toggling so a stale sample never matches
         rdData <= (take && !memReq.write) ? mem[memReq.addr[8:2]] : ~rdData;
         // group store image kept untouched until reloaded
         if (take && memReq.write) mem[memReq.addr[8:2]] <= memReq.data;
      end
   end
endmodule : fpxfr_host_mem
`default_nettype wire

// [fpxfr_core_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// checker on the core ports
module fpxfr_core_chk
   import fpxfr_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rst_n, // sync reset
   input wire logic insValid, // offer
   input wire logic [31:0] insWord, // instruction
   input wire logic [31:0] insBase, // base value
   input wire logic insReady, // idle
   input wire logic insClaim, // claimed
   input wire logic insRefuse, // refused
   input wire logic memValid, // request valid
   input wire fpxfr_pkg::fpxfr_memreq_t memReq, // request
   input wire logic memReady, // taken
   input wire logic baseWbValid, // writeback
   input wire logic [3:0] baseWbIndex, // base index
   input wire logic [31:0] baseWbValue, // new base
   input wire logic xferDone // finished
);
   logic [31:0] word_ff, base_ff, last_ff;
   logic seen_ff;
   logic [3:0] nWords_ff;
   wire take = insValid && insReady;
   wire memTake = memValid && memReady;
   wire cls = insWord[27:25] == CLS_CPDT;
   wire [3:0] cp = insWord[11:8];
   wire pk = insWord[LEN_HI_BIT] && insWord[LEN_LO_BIT];
   wire [31:0] offB = {22'h0, word_ff[7:0], 2'h0};
   wire [31:0] modBase = word_ff[UD_BIT] ? base_ff + offB : base_ff - offB;
   wire [1:0] len = {word_ff[LEN_HI_BIT], word_ff[LEN_LO_BIT]};
   wire grp = word_ff[11:8] == CP_GROUP;
   wire [3:0] expW = grp ? ((len == 2'h0) ? 4'hC : {2'h0, len} * 4'h3) : {2'h0, len} + 4'h1;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         word_ff <= 32'h0;
         base_ff <= 32'h0;
         last_ff <= 32'h0;
         seen_ff <= 1'b0;
         nWords_ff <= 4'h0;
      end else begin
         if (take) word_ff <= insWord;
         if (take) base_ff <= insBase;
         if (insClaim) seen_ff <= 1'b0;
         else if (memTake) seen_ff <= 1'b1;
         if (insClaim) nWords_ff <= 4'h0;
         else if (memTake) nWords_ff <= nWords_ff + 4'h1;
         if (memTake) last_ff <= memReq.addr;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   answer_once_a: assert property (take |=> insClaim ^ insRefuse)
      else $error("no single answer");
   class_refuse_a: assert property (take && !cls |=> insRefuse && insReady)
      else $error("foreign class taken");
   cpnum_refuse_a: assert property (take && cls && cp != CP_SINGLE && cp != CP_GROUP |=> insRefuse)
      else $error("foreign number taken");
   packed_refuse_a: assert property (take && cls && cp == CP_SINGLE && pk |=> insRefuse)
      else $error("packed taken");
   claim_ok_a: assert property (take && cls && (cp == CP_GROUP || (cp == CP_SINGLE && !pk)) |=> insClaim && !insReady)
      else $error("valid transfer not claimed");
   first_addr_a: assert property (memTake && !seen_ff |-> memReq.addr == (word_ff[P_BIT] ? modBase : base_ff))
      else $error("first address wrong");
   addr_step_a: assert property (memTake && seen_ff |-> memReq.addr == last_ff + WORD_BYTES)
      else $error("address step wrong");
   dir_flag_a: assert property (memValid |-> memReq.write == !word_ff[LS_BIT])
      else $error("direction wrong");
   word_count_a: assert property (xferDone |-> nWords_ff == expW)
      else $error("word count wrong");
   wb_value_a: assert property (baseWbValid |-> xferDone && baseWbValue == modBase && baseWbIndex == word_ff[19:16])
      else $error("writeback wrong");
   wb_gate_a: assert property (xferDone |-> baseWbValid == word_ff[WB_BIT])
      else $error("writeback gating wrong");
   done_bound_a: assert property (insClaim |-> ##[2:400] xferDone)
      else $error("transfer never done");
   cover property (insClaim ##[2:400] baseWbValid);
   cover property (take && cls && cp == CP_GROUP);
   cover property (memValid && !memReady ##1 memValid);
endmodule : fpxfr_core_chk
bind fpxfr_core fpxfr_core_chk i_chk (.ref_clk, .rst_n, .insValid, .insWord, .insBase,
   .insReady, .insClaim, .insRefuse, .memValid, .memReq, .memReady, .baseWbValid,
   .baseWbIndex, .baseWbValue, .xferDone);
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module testbench;
   import fpxfr_pkg::*;
   logic ref_clk = 1'b0, rst_n = 1'b0, insValid = 1'b0, expandedPackedSelect = 1'b0;
   logic swWr = 1'b0, swRd = 1'b0, slow = 1'b0;
   logic [31:0] insWord = 32'h0, insBase = 32'h0, swWdata = 32'h0;
   logic [4:0] swAddr = 5'h0;
   logic insReady, insClaim, insRefuse, memValid, memReady, rdValid, baseWbValid, xferDone;
   logic [31:0] rdData, swRdata, baseWbValue, d;
   logic [3:0] baseWbIndex;
   fpxfr_memreq_t memReq;
   int n_fail = 0, total_checks = 0;
   always #50 ref_clk = ~ref_clk;
   fpxfr_core i_fpxfr_core (.ref_clk, .rst_n, .insValid, .insWord, .insBase,
      .expandedPackedSelect, .insReady, .insClaim, .insRefuse, .memValid, .memReq,
      .memReady, .rdValid, .rdData, .baseWbValid, .baseWbIndex, .baseWbValue, .xferDone,
      .swAddr, .swWdata, .swWr, .swRd, .swRdata);
   fpxfr_host_mem i_fpxfr_host_mem (.ref_clk, .rst_n, .memValid, .memReq, .memReady,
      .rdValid, .rdData, .slow);
   task automatic stop_test;
      $display("fails %0d checks %0d", n_fail, total_checks);
      if (n_fail == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test
   // ==========
   // base register 5, word offsets only, never the pc
   function automatic logic [31:0] ins(input logic p, u, wb, ls, input logic [1:0] len,
      input logic [2:0] fd, input logic [3:0] cp, input logic [7:0] off);
      return {4'hE, 3'h6, p, u, len[1], wb, ls, 4'h5, len[0], fd, cp, off};
   endfunction : ins
   task automatic run(input logic [31:0] w, b, input logic cl, wbe, input logic [31:0] wv);
      int i;
      for (i = 0; i < 50 && insReady !== 1'b1; i++) @(posedge ref_clk) #1;
      if (i == 50) begin n_fail++; stop_test; end
      @(posedge ref_clk) begin insValid <= 1'b1; insWord <= w; insBase <= b; end
      @(posedge ref_clk) insValid <= 1'b0;
      #1 `CHK(insClaim, cl)
      `CHK(insRefuse, !cl)
      if (cl) begin
         for (i = 0; i < 500 && xferDone !== 1'b1; i++) @(posedge ref_clk) #1;
         if (i == 500) begin n_fail++; stop_test; end
         `CHK(baseWbValid, wbe)
         if (wbe) `CHK(baseWbValue, wv)
      end
   endtask : run
   task automatic sw_write(input logic [4:0] a, input logic [31:0] v);
      @(posedge ref_clk) begin swWr <= 1'b1; swAddr <= a; swWdata <= v; end
      @(posedge ref_clk) swWr <= 1'b0;
   endtask : sw_write
   task automatic sw_read(input logic [4:0] a, output logic [31:0] v);
      @(posedge ref_clk) begin swRd <= 1'b1; swAddr <= a; end
      @(posedge ref_clk) swRd <= 1'b0;
      #1 v = swRdata;
   endtask : sw_read
   // ==========
   // scenarios
   task automatic t_refuse;
      run(32'hEE000100, 32'h0, 1'b0, 1'b0, 32'h0);
      run(ins(1, 1, 0, 0, 2'h0, 3'h0, 4'h3, 8'h0), 32'h0, 1'b0, 1'b0, 32'h0);
      run(ins(1, 1, 0, 0, 2'h0, 3'h0, 4'h0, 8'h0), 32'h0, 1'b0, 1'b0, 32'h0);
      for (int e = 0; e < 2; e++) begin
         expandedPackedSelect <= e[0];
         run(ins(1, 1, 0, 1, 2'h3, 3'h0, CP_SINGLE, 8'h0), 32'h0, 1'b0, 1'b0, 32'h0);
      end
   endtask : t_refuse
   task automatic t_store;
      sw_write(5'h3, 32'h00003FFF);
      sw_write(5'h4, 32'h800000C0);
      sw_write(5'h5, 32'h0);
      run(ins(1, 1, 1, 0, 2'h0, 3'h1, CP_SINGLE, 8'h2), 32'h100, 1'b1, 1'b1, 32'h108);
      `CHK(i_fpxfr_host_mem.mem[7'h42], 32'h3F800001)
      run(ins(0, 0, 0, 0, 2'h1, 3'h1, CP_SINGLE, 8'h5), 32'h80, 1'b1, 1'b0, 32'h0);
      `CHK(i_fpxfr_host_mem.mem[7'h20], 32'h3FF00000)
      `CHK(i_fpxfr_host_mem.mem[7'h21], 32'h18000000)
   endtask : t_store
   task automatic t_load;
      i_fpxfr_host_mem.mem[7'h30] = 32'h40400000;
      run(ins(0, 0, 1, 1, 2'h0, 3'h3, CP_SINGLE, 8'h1), 32'hC0, 1'b1, 1'b1, 32'hBC);
      sw_read(5'h9, d);
      `CHK(d, 32'h00004000)
      sw_read(5'hA, d);
      `CHK(d, 32'hC0000000)
   endtask : t_load
   task automatic t_group;
      for (int i = 0; i < 24; i++) sw_write(i[4:0], 32'hA5A50000 + i);
      slow <= 1'b1;
      run(ins(1, 0, 1, 0, 2'h0, 3'h6, CP_GROUP, 8'hC), 32'h200, 1'b1, 1'b1, 32'h1D0);
      slow <= 1'b0;
      `CHK(i_fpxfr_host_mem.mem[7'h74], 32'hA5A50012)
      `CHK(i_fpxfr_host_mem.mem[7'h7A], 32'hA5A50000)
      for (int i = 0; i < 24; i++) if (i < 6 || i > 17) sw_write(i[4:0], 32'h0);
      run(ins(0, 1, 0, 1, 2'h0, 3'h6, CP_GROUP, 8'hC), 32'h1D0, 1'b1, 1'b0, 32'h0);
      for (int i = 0; i < 24; i++) begin
         sw_read(i[4:0], d);
         `CHK(d, 32'hA5A50000 + i)
      end
   endtask : t_group
   task automatic t_counts;
      for (int c = 1; c < 5; c++) begin
         slow <= c[0];
         run(ins(0, 1, 1, 1, c[1:0], c[2:0], CP_GROUP, 8'(3 * c)), 32'h100, 1'b1, 1'b1,
            32'h100 + 12 * c);
      end
   endtask : t_counts
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_refuse;
      t_store;
      t_load;
      t_group;
      t_counts;
      stop_test;
   end
endmodule : testbench
`default_nettype wire
